// ===== hdl/dram_cycle_timing_map.vh
// Constants for the dynamic RAM cycle timing controller
`ifndef DRAM_CYCLE_TIMING_MAP_VH
`define DRAM_CYCLE_TIMING_MAP_VH

// ---------------------------------------------------------------
// Clock
// ---------------------------------------------------------------
`define CLK_PERIOD_NS 100
// ---------------------------------------------------------------
// Refresh spacing in clock periods (timer tick at the midpoint)
// ---------------------------------------------------------------
`define REF128_MIN 264
`define REF128_MAX 288
`define REF64_MIN 548
`define REF64_MAX 576
`define REF_CNT_W 10
// ---------------------------------------------------------------
// Cycle step positions, counted from the first cycle state
// ---------------------------------------------------------------
`define STEP_RAS 4'h0
`define STEP_MUX 4'h1
`define STEP_CAS 4'h2
`define STEP_ACK 4'h6
`define STEP_CAS_OFF 4'h6
`define STEP_END 4'hA
`define STEP_REF_END 4'h9
`define STEP_W 4
// ---------------------------------------------------------------
// Widths
// ---------------------------------------------------------------
`define ROW_CNT_W 8
`define MUX_W 7

`endif

// ===== hdl/dram_cycle_timing_controller.v
// Cycle sequencer for a dynamic RAM controller driven by one clock
//
// Overview of operation
// - All write timing and both acknowledges count from the read or store request's arrival.
// - In 128-row mode timed refreshes come 264 to 288 clock periods apart.
// - In 64-row mode timed refreshes come 548 to 576 clock periods apart.
// - Row strobe falls one to two clock periods after an accepted request.
// - Column strobe falls three to four clock periods after an accepted request.
// - System acknowledge asserts within two clock periods of request acceptance, unless a read or write arrived during refresh since the last read cycle ended.
// - Row address stays on the outputs one clock period after row strobe.
// - Column address held about five clock periods after column strobe falls.
// - Back-to-back refresh cycles each finish within thirteen clock periods.
// - An ordinary memory cycle finishes within twelve clock periods.
// - Read, store, protected select and refresh requests are synchronised internally.
// - Transfer acknowledge lasts four periods minimum, else until request removal.
// - Write strobe releases five periods after column strobe or on request removal.
// - Memory requests beat refresh; a running cycle is never disturbed.
// - Refresh asserts all row strobes; other strobes and acknowledges stay off.
// - Test cycle does a write cycle and clears the refresh row counter at its first step.
// - Write strobe goes active before the column strobe (early write).
`timescale 1ns/1ps
`default_nettype none
`include "dram_cycle_timing_map.vh"

module dram_cycle_timing_controller #(
  parameter ROW_W = `MUX_W,
  parameter REF128_TICK = (`REF128_MIN + `REF128_MAX) / 2,
  parameter REF64_TICK = (`REF64_MIN + `REF64_MAX) / 2
) (
  // Clock and reset
  input wire mclk,
  input wire rst,
  // Processor requests and row mode, active low except refresh and row mode
  input wire read_req_n,
  input wire store_req_n,
  input wire protected_select_n,
  input wire refresh_request,
  input wire row_mode_64,
  // Address and bank select, not latched
  input wire [ROW_W-1:0] row_addr,
  input wire [ROW_W-1:0] col_addr,
  input wire bank_select_lo,
  input wire bank_select_hi,
  // Memory array strobes and address
  output reg [3:0] ras_n,
  output reg cas_n,
  output reg we_n,
  output reg [ROW_W-1:0] muxed_address_outputs,
  // Processor acknowledges
  output reg system_ack_n,
  output reg transfer_ack_n
);

  // ---------------------------------------------------------------
  // States
  // ---------------------------------------------------------------
  localparam S_IDLE = 3'd0;
  localparam S_READ = 3'd1;
  localparam S_WRITE = 3'd2;
  localparam S_REFRESH = 3'd3;
  localparam S_TRANSFER_ACK_N = 3'd4;

  // One-hot active-low row strobe from the two bank selects
  function [3:0] bank_decode;
    input hi;
    input lo;
    begin
      bank_decode = ~(4'h1 << {hi, lo});
    end
  endfunction

  reg [2:0] state;
  reg [2:0] next_state;
  reg [`STEP_W-1:0] step;
  reg [`REF_CNT_W-1:0] ref_timer;
  reg [`ROW_CNT_W-1:0] row_count;
  reg rd_s1, rd_s2, wr_s1, wr_s2, pcs_s1, pcs_s2, rf_s1, rf_s2;
  reg refresh_pending;
  reg timer_due;
  reg test_cycle;
  reg delayed_system_ack_n;
  wire rd_act;
  wire wr_act;
  wire test_req;
  wire mem_req;
  wire [`REF_CNT_W-1:0] ref_limit;
  wire cycle_end;

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  // Two stages each; only the second stage is looked at
  // two-stage request sync
  always @(posedge mclk) begin
    if (rst) begin
      rd_s1 <= 1'b1;
      rd_s2 <= 1'b1;
      wr_s1 <= 1'b1;
      wr_s2 <= 1'b1;
      pcs_s1 <= 1'b1;
      pcs_s2 <= 1'b1;
      rf_s1 <= 1'b0;
      rf_s2 <= 1'b0;
    end else begin
      rd_s1 <= read_req_n;
      rd_s2 <= rd_s1;
      wr_s1 <= store_req_n;
      wr_s2 <= wr_s1;
      pcs_s1 <= protected_select_n;
      pcs_s2 <= pcs_s1;
      rf_s1 <= refresh_request;
      rf_s2 <= rf_s1;
    end
  end

  // Both strobes low is a test request, regardless of chip select
  assign test_req = ~rd_s2 & ~wr_s2;
  assign rd_act = ~rd_s2 & ~pcs_s2 & wr_s2;
  assign wr_act = ~wr_s2 & ~pcs_s2 & rd_s2;
  assign mem_req = rd_act | wr_act | test_req;

  // ---------------------------------------------------------------
  // Refresh timer and pending refresh
  // ---------------------------------------------------------------
  // timed refresh spacing
  assign ref_limit = row_mode_64 ? REF64_TICK[`REF_CNT_W-1:0] :
                                   REF128_TICK[`REF_CNT_W-1:0];

  // External refresh restarts the timer so timed ones never crowd it
  always @(posedge mclk) begin
    if (rst) begin
      ref_timer <= {`REF_CNT_W{1'b0}};
      timer_due <= 1'b0;
    end else if (rf_s2 || (state == S_REFRESH && step == `STEP_RAS)) begin
      ref_timer <= {`REF_CNT_W{1'b0}};
      timer_due <= 1'b0;
    end else if (ref_timer == ref_limit - 1'b1) begin
      ref_timer <= {`REF_CNT_W{1'b0}};
      timer_due <= 1'b1;
    end else begin
      ref_timer <= ref_timer + 1'b1;
    end
  end

  // External request is latched; set wins over clear at cycle start
  always @(posedge mclk) begin
    if (rst)
      refresh_pending <= 1'b0;
    else if (rf_s2)
      refresh_pending <= 1'b1;
    else if (state == S_REFRESH && step == `STEP_RAS)
      refresh_pending <= 1'b0;
  end

  // ---------------------------------------------------------------
  // Cycle sequencer
  // ---------------------------------------------------------------
  assign cycle_end = (state == S_REFRESH) ? (step == `STEP_REF_END) :
                     (step == `STEP_END);

  always @* begin
    next_state = state;
    case (state)
      S_IDLE: begin
        if (wr_act || test_req)
          next_state = S_WRITE;
        else if (rd_act)
          next_state = S_READ;
        else if (refresh_pending || timer_due)
          next_state = S_REFRESH;
      end
      S_READ, S_WRITE: begin
        if (cycle_end)
          next_state = (rd_s2 && wr_s2) ? S_IDLE : S_TRANSFER_ACK_N;
      end
      S_TRANSFER_ACK_N: begin
        if (rd_s2 && wr_s2)
          next_state = S_IDLE;
      end
      S_REFRESH: begin
        if (cycle_end)
          next_state = S_IDLE;
      end
      default: next_state = S_IDLE;
    endcase
  end

  always @(posedge mclk) begin
    if (rst) begin
      state <= S_IDLE;
      step <= {`STEP_W{1'b0}};
    end else begin
      state <= next_state;
      if (next_state != state)
        step <= {`STEP_W{1'b0}};
      else if (state != S_IDLE && state != S_TRANSFER_ACK_N)
        step <= step + 1'b1;
    end
  end

  // Test cycle marker and delayed system acknowledge latch
  // test clears row counter
  always @(posedge mclk) begin
    if (rst) begin
      test_cycle <= 1'b0;
      delayed_system_ack_n <= 1'b0;
      row_count <= {`ROW_CNT_W{1'b0}};
    end else begin
      if (state == S_IDLE && next_state == S_WRITE)
        test_cycle <= test_req;
      if (state == S_WRITE && step == `STEP_RAS && test_cycle)
        row_count <= {`ROW_CNT_W{1'b0}};
      else if (state == S_REFRESH && cycle_end)
        row_count <= row_count + 1'b1;
      // Request seen during refresh delays the early acknowledge
      if (state == S_REFRESH && (rd_act || wr_act))
        delayed_system_ack_n <= 1'b1;
      else if (state == S_READ && cycle_end)
        delayed_system_ack_n <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Output strobes, address and acknowledges
  // ---------------------------------------------------------------
  // Everything counts from the synchronised request, so late requests shift all
  // timing tied to request arrival
  always @(posedge mclk) begin
    if (rst) begin
      ras_n <= 4'hF;
      cas_n <= 1'b1;
      we_n <= 1'b1;
      system_ack_n <= 1'b1;
      transfer_ack_n <= 1'b1;
      muxed_address_outputs <= {ROW_W{1'b1}};
    end else begin
      case (next_state)
        S_READ, S_WRITE: begin
          ras_n <= bank_decode(bank_select_hi, bank_select_lo);
          // row address one period then column
          // Column address from the second clock, one clock ahead of the column strobe
          if (state == next_state)
            muxed_address_outputs <= ~col_addr;
          else
            muxed_address_outputs <= ~row_addr;
          cas_n <= ~(state == next_state && step >= `STEP_MUX &&
                     step < `STEP_CAS_OFF);
          // early write, release on timing or request removal
          we_n <= ~(next_state == S_WRITE && step < `STEP_ACK && ~wr_s2);
          // early acknowledge unless delayed by refresh
          system_ack_n <= delayed_system_ack_n ? ~(state == next_state && step >= `STEP_ACK)
                                       : 1'b0;
          transfer_ack_n <= ~(state == next_state && step >= `STEP_ACK);
        end
        S_TRANSFER_ACK_N: begin
          ras_n <= 4'hF;
          cas_n <= 1'b1;
          we_n <= 1'b1;
          system_ack_n <= 1'b0;
          transfer_ack_n <= 1'b0;
        end
        S_REFRESH: begin
          ras_n <= 4'h0;
          cas_n <= 1'b1;
          we_n <= 1'b1;
          system_ack_n <= 1'b1;
          transfer_ack_n <= 1'b1;
          muxed_address_outputs <= ~row_count[ROW_W-1:0];
        end
        default: begin
          ras_n <= 4'hF;
          cas_n <= 1'b1;
          we_n <= 1'b1;
          system_ack_n <= 1'b1;
          transfer_ack_n <= 1'b1;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// ===== tb/dram_timing_checker_assertions.sv
// Port checker for the DRAM cycle timing controller
`timescale 1ns/1ps
`default_nettype none
module dram_timing_checker #(parameter ROW_W = 7) (
  // Clock, reset and requests
  input wire logic mclk,
  input wire logic rst,
  input wire logic read_req_n,
  input wire logic store_req_n,
  input wire logic [ROW_W-1:0] row_addr,
  input wire logic [ROW_W-1:0] col_addr,
  // Memory side and acknowledges
  input wire logic [3:0] ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [ROW_W-1:0] muxed_address_outputs,
  input wire logic system_ack_n,
  input wire logic transfer_ack_n
);
  // ----------------------------------------
  // Cycle shape
  // ----------------------------------------
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  sequence cas_start; $fell(cas_n); endsequence
  // Column address must not move while the strobe is low
  sequence col_phase; (!cas_n && $stable(muxed_address_outputs))[*5] ##1 cas_n; endsequence
  cas_lag_a: assert property (cas_start |-> $past(ras_n, 2) != 4'hF && $past(ras_n, 3) == 4'hF)
    else $error("column strobe not two clocks after row strobe");
  col_hold_a: assert property (cas_start |-> col_phase)
    else $error("column strobe or column address not held five clocks");
  ack_delay_a: assert property ($fell(transfer_ack_n) |-> $past(cas_n, 5) == 1'b0 && $past(cas_n, 6) == 1'b1)
    else $error("transfer ack not five clocks after column strobe");
  ack_hold_a: assert property (!transfer_ack_n && !(read_req_n && store_req_n) |=> !transfer_ack_n)
    else $error("transfer ack dropped while request held");
  system_ack_n_in_cycle_a: assert property ($fell(system_ack_n) |-> ras_n != 4'hF && ras_n != 4'h0)
    else $error("system ack outside a memory cycle");
  refresh_quiet_a: assert property (ras_n == 4'h0 |-> cas_n && we_n && system_ack_n && transfer_ack_n)
    else $error("strobe or ack active in refresh");
  bank_hot_a: assert property (!cas_n |-> $onehot(~ras_n))
    else $error("row strobe not one-hot in access");
  early_write_a: assert property (cas_start |-> we_n || $past(!we_n, 2))
    else $error("write strobe not ahead of column strobe");
  cycle_bound_a: assert property ($fell(&ras_n) |-> ##[1:12] &ras_n)
    else $error("cycle longer than twelve clocks");
  row_hold_a: assert property ($fell(&ras_n) && ras_n != 4'h0 |->
    muxed_address_outputs == ~row_addr ##1 muxed_address_outputs == ~col_addr)
    else $error("row address not held one clock");
endmodule
bind dram_cycle_timing_controller dram_timing_checker #(.ROW_W(ROW_W)) chk_i (.mclk(mclk),
  .rst(rst), .read_req_n(read_req_n), .store_req_n(store_req_n), .row_addr(row_addr),
  .col_addr(col_addr), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
  .muxed_address_outputs(muxed_address_outputs), .system_ack_n(system_ack_n),
  .transfer_ack_n(transfer_ack_n));
`default_nettype wire

// ===== tb/cpu_bus_model.sv
// Processor bus model issuing read, write and test requests
`timescale 1ns/1ps
`default_nettype none
module cpu_bus_model (
  // Clock and controller answers
  input wire logic mclk,
  input wire logic [3:0] ras_n,
  input wire logic transfer_ack_n,
  // Requests, address and bank select
  output logic read_req_n,
  output logic store_req_n,
  output logic protected_select_n,
  output logic [6:0] row_addr,
  output logic [6:0] col_addr,
  output logic bank_select_lo,
  output logic bank_select_hi
);
  // Bus idle at start
  initial begin
    {read_req_n, store_req_n, protected_select_n} = 3'h7;
    {row_addr, col_addr, bank_select_hi, bank_select_lo} = 16'h0;
  end
  // One access; kind 0 read, 1 write, 2 test
  task go(input logic [1:0] kind, input logic [1:0] bank, input logic [6:0] row,
    input logic [6:0] col);
    int n;
    begin
      @(posedge mclk);
      #5;
      // address and bank stay put all cycle
      {bank_select_hi, bank_select_lo} = bank;
      row_addr = row;
      col_addr = col;
      // the write strobe reaches the array with no outside delay
      // test is both requests low, select left off
      protected_select_n = (kind == 2'h2);
      read_req_n = (kind == 2'h1);
      store_req_n = (kind == 2'h0);
      n = 0;
      while (transfer_ack_n !== 1'b0 && n < 40) begin
        @(posedge mclk);
        #1;
        n++;
      end
      #4;
      {read_req_n, store_req_n} = 2'h3;
      // next request only after the row strobe ends
      n = 0;
      while (ras_n !== 4'hF && n < 40) begin
        @(posedge mclk);
        #1;
        n++;
      end
      #4;
      protected_select_n = 1'b1;
      // Released lines show the inverse, not the last value
      row_addr = ~row;
      col_addr = ~col;
    end
  endtask
endmodule
`default_nettype wire

// ===== tb/tb_top.sv
// Self-checking bench for the DRAM cycle timing controller
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic refresh_request = 1'b0;
  logic row_mode_64 = 1'b0;
  wire read_req_n, store_req_n, protected_select_n, bank_select_lo, bank_select_hi;
  wire [6:0] row_addr, col_addr, muxed_address_outputs;
  wire [3:0] ras_n;
  wire cas_n, we_n, system_ack_n, transfer_ack_n;
  int fails = 0;
  int num_checks = 0;
  // 10 MHz clock
  always #50 mclk = ~mclk;
  dram_cycle_timing_controller DUT (.mclk(mclk), .rst(rst), .read_req_n(read_req_n),
    .store_req_n(store_req_n), .protected_select_n(protected_select_n),
    .refresh_request(refresh_request), .row_mode_64(row_mode_64), .row_addr(row_addr),
    .col_addr(col_addr), .bank_select_lo(bank_select_lo), .bank_select_hi(bank_select_hi),
    .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .muxed_address_outputs(muxed_address_outputs),
    .system_ack_n(system_ack_n), .transfer_ack_n(transfer_ack_n));
  cpu_bus_model cpu (.mclk(mclk), .ras_n(ras_n), .transfer_ack_n(transfer_ack_n),
    .read_req_n(read_req_n), .store_req_n(store_req_n),
    .protected_select_n(protected_select_n), .row_addr(row_addr), .col_addr(col_addr),
    .bank_select_lo(bank_select_lo), .bank_select_hi(bank_select_hi));
  // Compare one value and report at once
  task chk(input logic [7:0] got, input logic [7:0] exp);
    begin
      num_checks++;
      if (got !== exp) begin
        fails++;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  // Bounded wait for a row strobe pattern
  task wait_ras(input logic [3:0] v, output int n);
    begin
      n = 0;
      while (ras_n !== v && n < 700) begin
        @(posedge mclk);
        #1;
        n++;
      end
    end
  endtask
  // One access, optionally racing an external refresh
  task mem_cycle(input logic [1:0] kind, input logic [1:0] bank, input logic ext);
    int n;
    begin
      fork
        cpu.go(kind, bank, 7'h15, 7'h6A);
      join_none
      @(posedge mclk);
      #5;
      // refresh raised together with the request, so memory goes first
      refresh_request = ext;
      #1;
      n = 0;
      while (ras_n === 4'hF && n < 10) begin
        @(posedge mclk);
        #1;
        n++;
      end
      chk({7'h0, n >= 2 && n <= 3}, 8'h1);
      chk({4'h0, ras_n}, {4'h0, ~(4'h1 << bank)});
      chk({6'h0, we_n, system_ack_n}, {6'h0, kind == 2'h0, 1'b0});
      chk({1'b0, muxed_address_outputs}, {1'b0, 7'h6A});
      #4;
      refresh_request = 1'b0;
      n = 0;
      while (transfer_ack_n !== 1'b0 && n < 20) begin
        @(posedge mclk);
        #1;
        n++;
      end
      chk({7'h0, n == 7}, 8'h1);
      wait_ras(4'hF, n);
      if (ext) begin
        wait_ras(4'h0, n);
        chk({7'h0, n < 10}, 8'h1);
        wait_ras(4'hF, n);
        chk({7'h0, n <= 10}, 8'h1);
      end
      repeat (3) @(posedge mclk);
      $display("access kind %0d bank %0d done", kind, bank);
    end
  endtask
  // Timed refresh spacing and refresh row address
  task ref_space(input logic m, input int lo, input int hi, input logic [6:0] adr);
    int n, t;
    begin
      row_mode_64 = m;
      wait_ras(4'hF, n);
      wait_ras(4'h0, n);
      chk({1'b0, muxed_address_outputs}, {1'b0, adr});
      wait_ras(4'hF, t);
      wait_ras(4'h0, n);
      chk({7'h0, n + t >= lo && n + t <= hi}, 8'h1);
      $display("refresh spacing %0d done", n + t);
    end
  endtask
  // Verdict and end of run
  task end_of_test;
    begin
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  // Hang guard, well past the longest refresh runs
  initial begin
    #600000;
    fails++;
    end_of_test();
  end
  // Main sequence
  initial begin
    repeat (6) @(posedge mclk);
    #5;
    rst = 1'b0;
    for (int b = 0; b < 4; b++) mem_cycle(2'h0, 2'(b), 1'b0);
    mem_cycle(2'h1, 2'h2, 1'b0);
    mem_cycle(2'h0, 2'h1, 1'b1);
    mem_cycle(2'h2, 2'h3, 1'b0);
    ref_space(1'b0, 264, 288, 7'h7F);
    ref_space(1'b1, 548, 576, 7'h7D);
    end_of_test();
  end
endmodule
`default_nettype wire
